// ### rtl/hcs_pkg.sv
// Package: register map, field positions, codes and reset values
`default_nettype none
package hcs_pkg;
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_DELAY   = 8'h04;
  localparam logic [7:0] OFS_RATE    = 8'h08;
  localparam logic [7:0] OFS_DEPTH   = 8'h0C;
  localparam logic [7:0] OFS_BUFSTAT = 8'h10;
  localparam logic [7:0] OFS_CMD     = 8'h14;
  localparam logic [7:0] OFS_LINES   = 8'h18;
  localparam logic [7:0] OFS_ISTAT   = 8'h1C;
  localparam logic [7:0] OFS_IMASK   = 8'h20;
  // CTRL fields
  localparam int CTRL_TXSEL   = 0;
  localparam int CTRL_TXINV   = 2;
  localparam int CTRL_RXSEL   = 4;
  localparam int CTRL_RXCINV  = 6;
  localparam int CTRL_RXDINV  = 7;
  localparam int CTRL_SVC_ACT = 8;
  localparam logic [8:0] CTRL_RST  = 9'h000;
  localparam logic [23:0] DELAY_RST = 24'h004E20;
  localparam logic [31:0] RATE_RST  = 32'h003E8000;
  // Delay is counted in 0.0001 ms steps
  localparam logic [23:0] DELAY_MIN = 24'h000001;
  localparam logic [23:0] DELAY_MAX = 24'h98967F;
  localparam logic [55:0] STEPS_PER_S = 56'h0000000098_9680;
  localparam logic [7:0] PCT_CENTRE = 8'h64;
  localparam logic [31:0] CMD_RECENTRE = 32'h0000_0001;
  localparam logic [31:0] CMD_CLR_SLIP = 32'h0000_0000;
  // Interrupt status bits
  localparam int IRQ_SLIP  = 0;
  localparam int IRQ_RANGE = 1;
  localparam int IRQ_LINES = 2;
  localparam int INT_DIV_DEF = 16;
  localparam int BUF_BITS_DEF = 1024;
  typedef enum logic [1:0] {
    TXC_INTERNAL = 2'b00,
    TXC_TT       = 2'b01,
    TXC_RX       = 2'b10
  } hcs_txsel_t;
  typedef enum logic [1:0] {
    RXC_DMD      = 2'b00,
    RXC_INTERNAL = 2'b01,
    RXC_MOD      = 2'b10,
    RXC_TT       = 2'b11
  } hcs_rxsel_t;
endpackage
`default_nettype wire

// ### rtl/hcs_sync.sv
// Two-stage synchroniser with rising edge detection
`default_nettype none
module hcs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign level = s2_reg;
  assign rise  = s2_reg & ~s3_reg;
endmodule
`default_nettype wire

// ### rtl/hcs_elastic.sv
// Receive elastic bit buffer with centring and slip recovery
`default_nettype none
module hcs_elastic #(
  parameter int MAX_BITS = 1024,
  parameter int AW       = $clog2(MAX_BITS)
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        en,
  input  wire logic        wr,
  input  wire logic        wr_bit,
  input  wire logic        rd,
  input  wire logic        recentre,
  input  wire logic [AW:0] depth,
  output logic             rd_bit,
  output logic      [AW:0] fill,
  output logic             slip
);
  logic [MAX_BITS-1:0] mem_reg;
  logic [AW-1:0]       wp_reg;
  logic [AW-1:0]       rp_reg;
  logic [AW:0]         fill_reg;
  logic                slip_reg;
  logic                bit_reg;
  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p, input logic [AW:0] d);
    logic [AW:0] n;
    n = {1'b0, p} + (AW+1)'(1);
    wrap_inc = (n >= d) ? '0 : n[AW-1:0];
  endfunction
  wire [AW:0]   half      = depth >> 1;
  wire [AW:0]   wp_ext    = {1'b0, wp_reg};
  wire          over      = wr && !rd && (fill_reg >= depth);
  wire          under     = rd && !wr && (fill_reg == '0);
  // A depth cut below the fill recentres on the next edge, so fill exceeds depth for one cycle at most
  wire          shrink    = fill_reg > depth;
  wire          resync    = !en || recentre || over || under || shrink;
  wire [AW:0]   rp_lo     = wp_ext - half;
  wire [AW:0]   rp_hi     = wp_ext + depth - half;
  wire [AW-1:0] rp_centre = (wp_ext >= half) ? rp_lo[AW-1:0] : rp_hi[AW-1:0];
  wire [AW:0]   fill_next = fill_reg + (AW+1)'(wr) - (AW+1)'(rd);
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_reg  <= '0;
      wp_reg   <= '0;
      rp_reg   <= '0;
      fill_reg <= '0;
      slip_reg <= 1'b0;
      bit_reg  <= 1'b0;
    end else begin
      slip_reg <= en && (over || under); // RULE_10
      if (en && wr) begin
        mem_reg[wp_reg] <= wr_bit;
        wp_reg          <= wrap_inc(wp_reg, depth);
      end
      if (resync) begin
        rp_reg   <= rp_centre; // RULE_06 RULE_10
        fill_reg <= half;
      end else begin
        fill_reg <= fill_next;
        if (rd) begin
          rp_reg <= wrap_inc(rp_reg, depth);
        end
      end
      if (en && rd && !under) begin
        bit_reg <= mem_reg[rp_reg];
      end
    end
  end
  assign rd_bit = bit_reg;
  assign fill   = fill_reg;
  assign slip   = slip_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  recentre_fill_a: assert property (en && recentre |=> fill == $past(half)) // RULE_06
    else $error("buffer not centred after command");
  slip_recover_a: assert property (en && (over || under) |=> slip && fill == $past(half)) // RULE_10
    else $error("slip did not recentre buffer");
  fill_bound_a: assert property (en && $stable(depth) && !$past(recentre) |-> fill <= depth)
    else $error("fill exceeds depth");
  slip_seen_c: cover property (en && over);
endmodule
`default_nettype wire

// ### rtl/hcs_hssi_clk_buf.sv
// Serial interface clock selection, polarity and receive elastic buffer
// Function
// RULE_01: Transmit data is timed by code 0 internal, 1 terminal timing clock, 2 receive clock.
// RULE_02: Transmit data, receive clock and receive data each pass or invert by code 0 or 1.
// RULE_03: Receive clock is 0 demod, 1 internal, 2 modulator, 3 terminal; 0 bypasses the buffer.
// RULE_04: Buffer size follows a delay of 0.0001 to 999.9999 ms, limited by the receive rate.
// RULE_05: The resulting buffer depth in bits is readable.
// RULE_06: A command value 1 re-centres the buffer.
// RULE_07: Slips are counted and a command value 0 clears the count.
// RULE_08: Fill is reported in percent, 100 being centre, only while the buffer is used.
// RULE_09: Each handshake line, and service channel lines when active, reads as a flag.
// RULE_10: Overflow or underflow counts a slip and re-centres the buffer by itself.
// RULE_11: The buffer is written on the demod clock and read on the chosen receive clock.
`default_nettype none
module hcs_hssi_clk_buf #(
  parameter int BUF_BITS = hcs_pkg::BUF_BITS_DEF,
  parameter int INT_DIV  = hcs_pkg::INT_DIV_DEF,
  parameter int AW       = $clog2(BUF_BITS)
) (
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        TT_CLK,
  input  wire logic        SEND_DATA,
  input  wire logic        DMD_CLK,
  input  wire logic        DMD_DATA,
  input  wire logic        MOD_CLK,
  input  wire logic        TA,
  input  wire logic        CA,
  input  wire logic        SVC_RTS,
  input  wire logic        SVC_CTS,
  input  wire logic        SVC_DCD,
  input  wire logic        SVC_DTR,
  input  wire logic        SVC_DSR,
  output logic             TX_DATA,
  output logic             TX_STROBE,
  output logic             RX_CLK,
  output logic             RX_DATA,
  output logic             IRQ
);
  import hcs_pkg::*;
  logic [11:0] pin_lvl;
  logic [11:0] pin_rise;
  hcs_sync #(.W(12)) u_sync (
    .clk   (MCLK),
    .rst   (RESET),
    .din   ({SVC_DSR, SVC_DTR, SVC_DCD, SVC_CTS, SVC_RTS, CA, TA,
             MOD_CLK, DMD_DATA, DMD_CLK, SEND_DATA, TT_CLK}),
    .level (pin_lvl),
    .rise  (pin_rise)
  );
  wire tt_lvl   = pin_lvl[0];
  wire tt_rise  = pin_rise[0];
  wire sd_lvl   = pin_lvl[1];
  wire dmd_lvl  = pin_lvl[2];
  wire dmd_rise = pin_rise[2];
  wire dd_lvl   = pin_lvl[3];
  wire mod_lvl  = pin_lvl[4];
  wire mod_rise = pin_rise[4];

  logic [8:0]    ctrl_reg;
  logic [23:0]   delay_reg;
  logic [31:0]   rate_reg;
  logic [AW:0]   depth_reg;
  logic          range_reg;
  logic [15:0]   slip_cnt_reg;
  logic [7:0]    pct_reg;
  logic [6:0]    lines_reg;
  logic [2:0]    istat_reg;
  logic [2:0]    imask_reg;
  logic          recentre_reg;
  logic [31:0]   prdata_reg;
  logic          pready_reg;
  logic          pslverr_reg;
  logic [15:0]   div_reg;
  logic          int_clk_reg;
  logic          tx_data_reg;
  logic          tx_stb_reg;
  logic          rx_clk_reg;
  logic          rx_data_reg;
  logic          irq_reg;

  // Bus decode; the answer comes one cycle into the access phase
  wire acc      = PSEL && PENABLE && !pready_reg;
  wire wr_do    = PSEL && PENABLE && pready_reg && PWRITE;
  wire sel_ctrl = PADDR == OFS_CTRL;
  wire sel_dly  = PADDR == OFS_DELAY;
  wire sel_rate = PADDR == OFS_RATE;
  wire sel_dep  = PADDR == OFS_DEPTH;
  wire sel_bst  = PADDR == OFS_BUFSTAT;
  wire sel_cmd  = PADDR == OFS_CMD;
  wire sel_lin  = PADDR == OFS_LINES;
  wire sel_ist  = PADDR == OFS_ISTAT;
  wire sel_imk  = PADDR == OFS_IMASK;
  wire addr_ok  = sel_ctrl | sel_dly | sel_rate | sel_dep | sel_bst | sel_cmd
                | sel_lin | sel_ist | sel_imk;
  wire cmd_cen  = wr_do && sel_cmd && PWDATA == CMD_RECENTRE;
  wire cmd_clr  = wr_do && sel_cmd && PWDATA == CMD_CLR_SLIP;

  wire [1:0] tx_sel  = ctrl_reg[CTRL_TXSEL +: 2];
  wire [1:0] rx_sel  = ctrl_reg[CTRL_RXSEL +: 2];
  wire       tx_inv  = ctrl_reg[CTRL_TXINV];
  wire       rxc_inv = ctrl_reg[CTRL_RXCINV];
  wire       rxd_inv = ctrl_reg[CTRL_RXDINV];
  wire       svc_act = ctrl_reg[CTRL_SVC_ACT];

  // Internal reference clock from the system clock
  wire int_wrap = div_reg == 16'(INT_DIV - 1);
  wire int_rise = int_wrap && !int_clk_reg;

  // Transmit tick from the chosen source; the unused code 3 falls back to internal
  wire tx_tick = (tx_sel == TXC_TT) ? tt_rise :
                 (tx_sel == TXC_RX) ? dmd_rise : int_rise; // RULE_01

  // Bypass disables the buffer, which the buffer then keeps centred
  wire buf_en  = rx_sel != RXC_DMD; // RULE_03
  wire rx_lvl  = (rx_sel == RXC_INTERNAL) ? int_clk_reg :
                 (rx_sel == RXC_MOD)      ? mod_lvl :
                 (rx_sel == RXC_TT)       ? tt_lvl : dmd_lvl;
  wire rx_tick = (rx_sel == RXC_INTERNAL) ? int_rise :
                 (rx_sel == RXC_MOD)      ? mod_rise :
                 (rx_sel == RXC_TT)       ? tt_rise : dmd_rise;
  wire buf_wr  = buf_en && dmd_rise; // RULE_11
  wire buf_rd  = buf_en && rx_tick; // RULE_11

  // Depth in bits = delay steps * rate / steps per second
  wire [55:0] dep_prod = 56'(delay_reg) * 56'(rate_reg);
  wire [55:0] dep_raw  = dep_prod / STEPS_PER_S;
  wire        dly_bad  = delay_reg < DELAY_MIN || delay_reg > DELAY_MAX;
  wire        dep_big  = dep_raw > 56'(BUF_BITS);
  wire        dep_low  = dep_raw < 56'h2;
  wire [AW:0] dep_next = (dly_bad || dep_low) ? (AW+1)'(2) :
                         dep_big ? (AW+1)'(BUF_BITS) : dep_raw[AW:0]; // RULE_04
  wire        rng_next = dly_bad || dep_low || dep_big;

  logic          buf_bit;
  logic [AW:0]   buf_fill;
  logic          buf_slip;
  hcs_elastic #(.MAX_BITS(BUF_BITS), .AW(AW)) u_buf (
    .clk      (MCLK),
    .rst      (RESET),
    .en       (buf_en),
    .wr       (buf_wr),
    .wr_bit   (dd_lvl),
    .rd       (buf_rd),
    .recentre (recentre_reg),
    .depth    (depth_reg),
    .rd_bit   (buf_bit),
    .fill     (buf_fill),
    .slip     (buf_slip)
  );

  wire [AW+8:0] pct_prod = (AW+9)'(buf_fill) * (AW+9)'(200);
  wire [AW+8:0] pct_raw  = pct_prod / (AW+9)'(depth_reg);
  wire [7:0]    pct_next = buf_en ? pct_raw[7:0] : 8'h00; // RULE_08
  wire [6:0]    lin_next = {svc_act ? pin_lvl[11:7] : 5'h00, pin_lvl[6:5]}; // RULE_09
  wire [2:0]    ev       = {lin_next != lines_reg, rng_next && !range_reg, buf_slip};
  wire [2:0]    w1c      = (wr_do && sel_ist) ? PWDATA[2:0] : 3'h0;
  wire [15:0]   slip_inc = (slip_cnt_reg == 16'hFFFF) ? slip_cnt_reg : slip_cnt_reg + 16'h0001;

  wire [31:0] rd_mux =
      sel_ctrl ? {23'h0, ctrl_reg} :
      sel_dly  ? {8'h00, delay_reg} :
      sel_rate ? rate_reg :
      sel_dep  ? 32'(depth_reg) : // RULE_05
      sel_bst  ? {slip_cnt_reg, 7'h00, buf_en, pct_reg} :
      sel_lin  ? {25'h0, lines_reg} :
      sel_ist  ? {29'h0, istat_reg} :
      sel_imk  ? {29'h0, imask_reg} : 32'h0000_0000;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= acc;
      pslverr_reg <= acc && !addr_ok;
      prdata_reg  <= (acc && !PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ctrl_reg     <= CTRL_RST;
      delay_reg    <= DELAY_RST;
      rate_reg     <= RATE_RST;
      imask_reg    <= 3'h0;
      recentre_reg <= 1'b0;
    end else begin
      if (wr_do && sel_ctrl) ctrl_reg <= PWDATA[8:0];
      if (wr_do && sel_dly) delay_reg <= PWDATA[23:0];
      if (wr_do && sel_rate) rate_reg <= PWDATA;
      if (wr_do && sel_imk) imask_reg <= PWDATA[2:0];
      recentre_reg <= cmd_cen; // RULE_06
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      depth_reg    <= (AW+1)'(2);
      range_reg    <= 1'b0;
      slip_cnt_reg <= 16'h0000;
      pct_reg      <= 8'h00;
      lines_reg    <= 7'h00;
      istat_reg    <= 3'h0;
      irq_reg      <= 1'b0;
    end else begin
      depth_reg <= dep_next;
      range_reg <= rng_next;
      pct_reg   <= pct_next;
      lines_reg <= lin_next;
      // A slip in the clearing cycle still counts
      if (buf_slip) slip_cnt_reg <= cmd_clr ? 16'h0001 : slip_inc; // RULE_10
      else if (cmd_clr) slip_cnt_reg <= 16'h0000; // RULE_07
      istat_reg <= (istat_reg & ~w1c) | ev;
      irq_reg   <= |(((istat_reg & ~w1c) | ev) & imask_reg);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      div_reg     <= 16'h0000;
      int_clk_reg <= 1'b0;
      tx_data_reg <= 1'b0;
      tx_stb_reg  <= 1'b0;
      rx_clk_reg  <= 1'b0;
      rx_data_reg <= 1'b0;
    end else begin
      div_reg <= int_wrap ? 16'h0000 : div_reg + 16'h0001;
      if (int_wrap) int_clk_reg <= !int_clk_reg;
      tx_stb_reg <= tx_tick;
      if (tx_tick) tx_data_reg <= sd_lvl ^ tx_inv; // RULE_02
      rx_clk_reg <= rx_lvl ^ rxc_inv; // RULE_02
      if (rx_tick) rx_data_reg <= (buf_en ? buf_bit : dd_lvl) ^ rxd_inv; // RULE_03
    end
  end

  assign PRDATA    = prdata_reg;
  assign PREADY    = pready_reg;
  assign PSLVERR   = pslverr_reg;
  assign TX_DATA   = tx_data_reg;
  assign TX_STROBE = tx_stb_reg;
  assign RX_CLK    = rx_clk_reg;
  assign RX_DATA   = rx_data_reg;
  assign IRQ       = irq_reg;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  apb_answer_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("access phase not answered in one cycle");
  tx_tt_clock_a: assert property (tx_sel == TXC_TT && tt_rise |=> TX_STROBE) // RULE_01
    else $error("transmit not timed by terminal clock");
  tx_polarity_a: assert property (tx_tick |=> TX_DATA == $past(sd_lvl ^ tx_inv)) // RULE_02
    else $error("transmit data polarity wrong");
  rx_bypass_a: assert property (rx_sel == RXC_DMD && dmd_rise |=>
                                RX_DATA == $past(dd_lvl ^ rxd_inv)) // RULE_03
    else $error("demod clock path not bypassed");
  depth_range_a: assert property (##1 depth_reg >= 2 && depth_reg <= BUF_BITS) // RULE_04
    else $error("buffer depth out of range");
  depth_read_a: assert property (PREADY && !PWRITE && PADDR == OFS_DEPTH && !PSLVERR
                                 |-> PRDATA == 32'($past(depth_reg))) // RULE_05
    else $error("depth readback wrong");
  slip_clear_a: assert property (cmd_clr |=> slip_cnt_reg <= 16'h0001) // RULE_07
    else $error("slip count not cleared");
  pct_idle_a: assert property (!buf_en |=> pct_reg == 8'h00) // RULE_08
    else $error("fill reported while buffer bypassed");
  svc_lines_a: assert property (!svc_act |=> lines_reg[6:2] == 5'h00) // RULE_09
    else $error("service lines shown while inactive");
  buf_write_a: assert property (buf_en && dmd_rise && !rx_tick && !recentre_reg // RULE_11
                                && buf_fill < depth_reg
                                |=> buf_fill == $past(buf_fill) + 1'b1)
    else $error("demod clock did not write the buffer");
  irq_level_a: assert property (istat_reg[IRQ_SLIP] && imask_reg[IRQ_SLIP] && !w1c[IRQ_SLIP]
                                |=> IRQ)
    else $error("interrupt not raised");
  rx_clock_a: assert property (1'b1 |=> RX_CLK == $past(rx_lvl ^ rxc_inv)) // RULE_02
    else $error("receive clock not the selected source");
  lines_flag_a: assert property (1'b1 |=> lines_reg[1:0] == $past(pin_lvl[6:5])) // RULE_09
    else $error("handshake line flag wrong");
  centre_cmd_a: assert property (cmd_cen |=> recentre_reg) // RULE_06
    else $error("recentre command lost");
  slip_count_a: assert property (buf_slip && !cmd_clr && slip_cnt_reg != 16'hFFFF // RULE_10
                                 |=> slip_cnt_reg == $past(slip_cnt_reg) + 16'h0001)
    else $error("slip not counted");
  pct_centre_a: assert property (buf_en && !depth_reg[0] && buf_fill == (depth_reg >> 1) // RULE_08
                                 |=> pct_reg == PCT_CENTRE)
    else $error("centred fill not reported as centre");
  irq_quiet_a: assert property ((istat_reg & imask_reg) == 3'h0 && ev == 3'h0 |=> !IRQ)
    else $error("interrupt raised with nothing pending");
  recentre_c: cover property (cmd_cen ##2 buf_en);
  slip_c: cover property (buf_slip ##1 IRQ);
  tx_tt_c: cover property (tx_sel == TXC_TT && tt_rise);
  bypass_c: cover property (rx_sel == RXC_DMD && dmd_rise);
endmodule
`default_nettype wire

// ### verification/hcs_term_model.sv
// Terminal equipment model: terminal timing clock and send data
`default_nettype none
module hcs_term_model (
  input  wire logic MCLK,
  input  wire logic run,
  input  wire logic alt,
  input  wire logic lvl,
  output var logic  TT_CLK,
  output var logic  SEND_DATA
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cnt = 3'h0;
  logic       tt_reg = 1'b0;
  logic       sd_reg = 1'b0;
  assign TT_CLK = tt_reg;
  assign SEND_DATA = sd_reg;
  // Clock stands low outside use; 160 ns period when running
  always @(posedge MCLK) begin
    if (!run) begin
      cnt <= 3'h0;
      tt_reg <= 1'b0;
      sd_reg <= lvl;
    end else begin
      cnt <= cnt + 3'h1;
      if (cnt == 3'h7) begin
        tt_reg <= ~tt_reg;
      end
      // Data moves on the falling edge so it is steady at the rising one
      if (cnt == 3'h7 && tt_reg) begin
        sd_reg <= alt ? ~sd_reg : lvl;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the serial clock select and receive buffer block
`default_nettype none
`define CHK(A, B) \
  begin \
    checked++; \
    if ((A) !== (B)) begin \
      num_errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, (A), (B)); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import hcs_pkg::*;
  logic        MCLK = 1'b0;
  logic        RESET = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        TT_CLK;
  logic        SEND_DATA;
  logic        DMD_CLK = 1'b0;
  logic        DMD_DATA = 1'b0;
  logic        MOD_CLK = 1'b0;
  logic        TA = 1'b0;
  logic        CA = 1'b0;
  logic [4:0]  svc = 5'h00;
  logic        TX_DATA;
  logic        TX_STROBE;
  logic        RX_CLK;
  logic        RX_DATA;
  logic        IRQ;
  logic        tt_run = 1'b0;
  logic        tt_alt = 1'b0;
  logic        dmd_run = 1'b0;
  logic [3:0]  dmd_cnt = 4'h0;
  logic [31:0] q_d;
  logic        q_e;
  int          num_errors = 0;
  int          checked = 0;
  logic [7:0]  ra[5] = '{OFS_CTRL, OFS_DELAY, OFS_RATE, OFS_IMASK, OFS_DEPTH};
  logic [31:0] rv[5] = '{32'h0, {8'h00, DELAY_RST}, RATE_RST, 32'h0, 32'h0000_0400};
  int          txn[4] = '{40, 10, 8, 40};
  int          rc[3] = '{0, 2, 3};

  hcs_hssi_clk_buf #(.INT_DIV(2)) i_hcs_hssi_clk_buf (
    .MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TT_CLK(TT_CLK), .SEND_DATA(SEND_DATA), .DMD_CLK(DMD_CLK), .DMD_DATA(DMD_DATA),
    .MOD_CLK(MOD_CLK), .TA(TA), .CA(CA), .SVC_RTS(svc[0]), .SVC_CTS(svc[1]),
    .SVC_DCD(svc[2]), .SVC_DTR(svc[3]), .SVC_DSR(svc[4]), .TX_DATA(TX_DATA),
    .TX_STROBE(TX_STROBE), .RX_CLK(RX_CLK), .RX_DATA(RX_DATA), .IRQ(IRQ)
  );
  hcs_term_model i_hcs_term_model (
    .MCLK(MCLK), .run(tt_run), .alt(tt_alt), .lvl(1'b1), .TT_CLK(TT_CLK),
    .SEND_DATA(SEND_DATA)
  );

  initial begin
    forever #5 MCLK = ~MCLK;
  end
  // Demodulator clock, 200 ns period while running
  always @(posedge MCLK) begin
    dmd_cnt <= (dmd_run && dmd_cnt != 4'h9) ? dmd_cnt + 4'h1 : 4'h0;
    DMD_CLK <= dmd_run ? DMD_CLK ^ (dmd_cnt == 4'h9) : 1'b0;
  end

  task automatic conclude();
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge MCLK);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) begin
      num_errors++;
      conclude();
    end else begin
      q_d = PRDATA;
      q_e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Counts transmit strobes and data bits that break the expected pattern
  task automatic txrun(input logic alt, input logic exp, output int n, output int bad);
    logic prev;
    logic first;
    n = 0;
    bad = 0;
    first = 1'b1;
    prev = 1'b0;
    repeat (160) begin
      @(posedge MCLK);
      if (TX_STROBE === 1'b1) begin
        n++;
        if (alt ? (!first && TX_DATA === prev) : (TX_DATA !== exp)) bad++;
        first = 1'b0;
        prev = TX_DATA;
      end
    end
  endtask

  initial begin
    int  n;
    int  bad;
    logic iv;
    repeat (12) @(posedge MCLK);
    RESET <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i]);
      `CHK(q_d, rv[i]);
    end
    rd(8'h40);
    `CHK({q_e, q_d}, 33'h1_0000_0000);
    rd(OFS_BUFSTAT);
    `CHK(q_d, 32'h0);
    // Receive clock source and polarity with static clocks
    MOD_CLK <= 1'b1;
    DMD_DATA <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      iv = i[0];
      wr(OFS_CTRL, (32'(rc[i / 2]) << CTRL_RXSEL) | (32'({iv, iv}) << CTRL_RXCINV));
      dmd_run <= 1'b1;
      cyc(50);
      dmd_run <= 1'b0;
      cyc(8);
      `CHK(RX_CLK, logic'((rc[i / 2] == 2) ^ iv));
      if (rc[i / 2] == 0) `CHK(RX_DATA, ~iv);
    end
    // Internal receive clock changes level every INT_DIV cycles
    wr(OFS_CTRL, 32'h0000_0010);
    cyc(2);
    n = 0;
    iv = RX_CLK;
    repeat (40) begin
      @(posedge MCLK);
      n += (RX_CLK !== iv);
      iv = RX_CLK;
    end
    `CHK(n, 20);
    // Transmit clock source for every code, data polarity for codes 0, 2 and 3
    for (int c = 0; c < 4; c++) begin
      iv = c[0];
      wr(OFS_CTRL, 32'(c) | (32'(iv) << CTRL_TXINV));
      tt_run <= (c == 1);
      tt_alt <= (c == 1);
      dmd_run <= (c == 2);
      cyc(20);
      txrun(c == 1, ~iv, n, bad);
      `CHK(n >= txn[c] - 1 && n <= txn[c] + 1, 1'b1);
      `CHK(bad, 0);
    end
    tt_run <= 1'b0;
    dmd_run <= 1'b0;
    wr(OFS_DEPTH, 32'h0);
    wr(OFS_DELAY, 32'h0000_03E8);
    wr(OFS_RATE, 32'h0009_C400);
    rd(OFS_DEPTH);
    `CHK(q_d, 32'h0000_0040);
    wr(OFS_ISTAT, 32'h7);
    wr(OFS_DELAY, 32'h0000_0001);
    rd(OFS_DEPTH);
    `CHK(q_d, 32'h0000_0002);
    rd(OFS_ISTAT);
    `CHK(q_d[IRQ_RANGE], 1'b1);
    wr(OFS_DELAY, 32'h0000_03E8);
    // Buffer in use, read clock held still, writes from the demodulator
    wr(OFS_CTRL, 32'h0000_0020);
    cyc(4);
    rd(OFS_BUFSTAT);
    `CHK(q_d, 32'h0000_0164);
    wr(OFS_IMASK, 32'h1);
    wr(OFS_ISTAT, 32'h7);
    dmd_run <= 1'b1;
    cyc(200);
    dmd_run <= 1'b0;
    cyc(30);
    rd(OFS_BUFSTAT);
    `CHK(q_d[7:0] > PCT_CENTRE, 1'b1);
    wr(OFS_CMD, CMD_RECENTRE);
    cyc(4);
    rd(OFS_BUFSTAT);
    `CHK(q_d, 32'h0000_0164);
    // One overflow in this window: 33 writes from centre at 200 ns each
    dmd_run <= 1'b1;
    cyc(1000);
    dmd_run <= 1'b0;
    cyc(30);
    rd(OFS_BUFSTAT);
    `CHK(q_d[31:16], 16'h0001);
    `CHK(IRQ, 1'b1);
    wr(OFS_CMD, CMD_CLR_SLIP);
    rd(OFS_BUFSTAT);
    `CHK(q_d[31:16], 16'h0000);
    wr(OFS_ISTAT, 32'h1);
    cyc(3);
    `CHK(IRQ, 1'b0);
    // Handshake lines, service channel off then on
    TA <= 1'b1;
    svc <= 5'b10101;
    wr(OFS_CTRL, 32'h0);
    cyc(6);
    rd(OFS_LINES);
    `CHK(q_d, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0100);
    rd(OFS_LINES);
    `CHK(q_d, 32'h0000_0055);
    rd(OFS_ISTAT);
    `CHK(q_d[IRQ_LINES], 1'b1);
    `CHK(IRQ, 1'b0);
    wr(OFS_IMASK, 32'h4);
    cyc(3);
    `CHK(IRQ, 1'b1);
    wr(OFS_ISTAT, 32'h4);
    cyc(3);
    `CHK(IRQ, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
